// ===== inc/query_readback_cfg.svh
// Constants for the query-register readback engine.
`ifndef QUERY_READBACK_CFG_SVH
`define QUERY_READBACK_CFG_SVH
`define ADDR_RF_PARAM 8'h20
`define ADDR_TEMP 8'h21
`define ADDR_STATUS 8'h22
`define ADDR_INFO 8'h23
`define ADDR_SWEEP_TABLE 8'h24
`define ADDR_LEVEL_DAC 8'h25
`define ADDR_SERIAL_DRAIN 8'h26
`define RESP_BYTES 3'h5
`define RESP_LAST 3'h4
`define CODE_RF1_FREQ 4'h0
`define CODE_SWEEP_START 4'h1
`define CODE_SWEEP_STOP 4'h2
`define CODE_SWEEP_STEP 4'h3
`define CODE_DWELL 4'h4
`define CODE_CYCLES 4'h5
`define CODE_BUF_PTS 4'h6
`define CODE_RF1_LEVEL 4'h7
`define CODE_RF2_FREQ 4'h8
`define CODE_PHASE 4'hA
`define FW_PHASE_MIN 8'h25
`define ZERO_BYTE 8'h00
`endif

// ===== inc/query_readback_pkg.sv
// Types shared by the query-register readback engine.
package query_readback_pkg;
	typedef enum logic [1:0] {
		idle_s,
		loaded_s,
		draining_s
	} resp_state_t;
	typedef logic [39:0] resp_word_t;
endpackage : query_readback_pkg

// ===== design/resp_shifter.sv
// Five-byte response shifter, most significant byte first.
`timescale 1ns/1ps
`include "query_readback_cfg.svh"
module resp_shifter
	import query_readback_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic load,
	input wire resp_word_t load_word,
	input wire logic pop,
	output logic [7:0] byte_out,
	output logic [2:0] bytes_left
);
	resp_word_t word_reg;
	logic [2:0] left_reg;
	wire logic do_pop = pop && (left_reg != 3'h0);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			word_reg <= 40'h0000000000;
			left_reg <= 3'h0;
		end else if (clk_en) begin
			// A new load replaces any unread bytes of the previous answer.
			if (load) begin
				word_reg <= load_word;
				left_reg <= `RESP_BYTES;
			end else if (do_pop) begin
				word_reg <= {word_reg[31:0], `ZERO_BYTE};
				left_reg <= left_reg - 3'h1;
			end
		end
	end
	assign byte_out = word_reg[39:32];
	assign bytes_left = left_reg;
endmodule : resp_shifter

// ===== design/query_register_readback.sv
// Query-register readback engine: decodes query writes and serves 5-byte answers.
`timescale 1ns/1ps
`include "query_readback_cfg.svh"
module query_register_readback
	import query_readback_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic wr_stb,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] wr_data_hi,
	input wire logic spi_path,
	input wire logic rd_stb,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic busy,
	output logic bad_instr,
	input wire logic [7:0] fw_version,
	input wire logic [39:0] rf1_freq,
	input wire logic [39:0] sweep_start,
	input wire logic [39:0] sweep_stop,
	input wire logic [39:0] sweep_step,
	input wire logic [31:0] dwell_time,
	input wire logic [31:0] cycle_count,
	input wire logic [31:0] buffer_points,
	input wire logic [15:0] rf1_level,
	input wire logic [15:0] rf2_freq,
	input wire logic [31:0] phase_float,
	input wire logic [31:0] temp_float,
	input wire logic [39:0] device_info,
	input wire logic [11:0] sweep_addr,
	input wire logic [39:0] sweep_entry,
	input wire logic [13:0] level_dac,
	input wire logic [3:0] list_config,
	input wire logic [3:0] sweep_config,
	input wire logic [14:0] operate_flags,
	input wire logic [6:0] pll_lock,
	input wire logic [8:0] status_low,
	output logic [11:0] sweep_addr_req
);
	resp_state_t state_reg, state_next;
	resp_word_t serial_buf_reg;
	logic serial_full_reg;
	logic bad_reg;
	logic [11:0] sweep_addr_reg;
	logic [7:0] byte_out;
	logic [2:0] bytes_left;

	// Left-justify a value of n valid bytes so the tail is zero.
	function automatic resp_word_t pad_msb(input logic [39:0] v, input logic [2:0] n);
		resp_word_t r;
		r = 40'h0000000000;
		unique case (n)
			3'h1: r = {v[7:0], 32'h00000000};
			3'h2: r = {v[15:0], 24'h000000};
			3'h3: r = {v[23:0], 16'h0000};
			3'h4: r = {v[31:0], `ZERO_BYTE};
			default: r = v;
		endcase
		return r;
	endfunction : pad_msb

	wire logic is_query = wr_stb && (wr_addr >= `ADDR_RF_PARAM) && (wr_addr <= `ADDR_SERIAL_DRAIN);
	wire logic [3:0] rf_code = wr_data[3:0];
	wire logic rf_upper_bad = (wr_addr == `ADDR_RF_PARAM) && (wr_data[7:4] != 4'h0);
	wire logic phase_ok = fw_version > `FW_PHASE_MIN;
	wire logic [11:0] sweep_req = {wr_data_hi[3:0], wr_data};
	// Status snapshot; the lower two bytes carry the frequently polled flags.
	wire resp_word_t status_word = {list_config, sweep_config, 1'b0, operate_flags, pll_lock, status_low};

	resp_word_t rf_word;
	logic rf_bad;
	always_comb begin
		rf_bad = 1'b0;
		unique case (rf_code)
			`CODE_RF1_FREQ: rf_word = pad_msb(rf1_freq, 3'h5);
			`CODE_SWEEP_START: rf_word = pad_msb(sweep_start, 3'h5);
			`CODE_SWEEP_STOP: rf_word = pad_msb(sweep_stop, 3'h5);
			`CODE_SWEEP_STEP: rf_word = pad_msb(sweep_step, 3'h5);
			`CODE_DWELL: rf_word = pad_msb({8'h00, dwell_time}, 3'h4);
			`CODE_CYCLES: rf_word = pad_msb({8'h00, cycle_count}, 3'h4);
			`CODE_BUF_PTS: rf_word = pad_msb({8'h00, buffer_points}, 3'h4);
			`CODE_RF1_LEVEL: rf_word = pad_msb({24'h000000, rf1_level}, 3'h2);
			`CODE_RF2_FREQ: rf_word = pad_msb({24'h000000, rf2_freq}, 3'h2);
			`CODE_PHASE: begin
				rf_word = phase_ok ? pad_msb({8'h00, phase_float}, 3'h4) : 40'h0000000000;
				rf_bad = !phase_ok;
			end
			default: begin
				rf_word = 40'h0000000000;
				rf_bad = 1'b1;
			end
		endcase
	end

	// Selected answer for the query being written.
	resp_word_t load_word;
	logic load_en;
	always_comb begin
		load_en = is_query;
		unique case (wr_addr)
			`ADDR_RF_PARAM: load_word = rf_word;
			`ADDR_TEMP: load_word = {temp_float, `ZERO_BYTE};
			`ADDR_STATUS: begin
				load_word = status_word;
				load_en = is_query && !spi_path;
			end
			`ADDR_INFO: load_word = device_info;
			`ADDR_SWEEP_TABLE: load_word = sweep_entry;
			`ADDR_LEVEL_DAC: load_word = pad_msb({26'h0000000, level_dac}, 3'h2);
			`ADDR_SERIAL_DRAIN: load_word = serial_buf_reg;
			default: load_word = 40'h0000000000;
		endcase
	end

	wire logic pop = rd_stb && (bytes_left != 3'h0);
	wire logic drain_hit = is_query && (wr_addr == `ADDR_SERIAL_DRAIN);
	wire logic status_spi = is_query && (wr_addr == `ADDR_STATUS) && spi_path;

	resp_shifter u_shift (
		.core_clk(core_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.load(load_en),
		.load_word(load_word),
		.pop(pop),
		.byte_out(byte_out),
		.bytes_left(bytes_left)
	);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			idle_s: if (load_en) state_next = loaded_s;
			loaded_s: if (pop) state_next = draining_s;
			draining_s: begin
				if (load_en) state_next = loaded_s;
				else if (pop && bytes_left == 3'h1) state_next = idle_s;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= idle_s;
			serial_buf_reg <= 40'h0000000000;
			serial_full_reg <= 1'b0;
			bad_reg <= 1'b0;
			sweep_addr_reg <= 12'h000;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			if (status_spi) begin
				serial_buf_reg <= status_word;
				serial_full_reg <= 1'b1;
			end else if (drain_hit) begin
				serial_buf_reg <= 40'h0000000000;
				serial_full_reg <= 1'b0;
			end
			if (is_query) begin
				bad_reg <= (wr_addr == `ADDR_RF_PARAM) && (rf_upper_bad || rf_bad);
			end
			if (is_query && wr_addr == `ADDR_SWEEP_TABLE) begin
				sweep_addr_reg <= sweep_req;
			end
			rd_valid <= pop;
			if (pop) begin
				rd_data <= byte_out;
			end
		end
	end

	assign busy = (bytes_left != 3'h0) || serial_full_reg;
	assign bad_instr = bad_reg;
	// Table address is taken straight from the write so the entry arrives with it.
	assign sweep_addr_req = is_query && wr_addr == `ADDR_SWEEP_TABLE ? sweep_req : sweep_addr_reg;
endmodule : query_register_readback

// ===== verif/query_host_model.sv
// Host controller model that writes query registers and reads answer bytes.
`timescale 1ns/1ps
module query_host_model(
	input wire logic core_clk,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic wr_stb,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic rd_stb
);
	initial begin
		wr_stb = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_stb = 1'b0;
	end
	task automatic query(input logic [7:0] addr, input logic [7:0] instr);
		wr_addr <= addr;
		wr_data <= instr;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
		wr_data <= ~instr;
	endtask : query
	// Six reads go out so that a sixth answer, which must never come, would be seen.
	task automatic fetch(output logic [39:0] word, output int n);
		word = 40'h0;
		n = 0;
		rd_stb <= 1'b1;
		for (int i = 1; i <= 7; i++) begin
			@(posedge core_clk);
			if (i == 6) rd_stb <= 1'b0;
			// The first answer stands from the second edge after the write, one edge after the first read.
			if (i >= 2 && rd_valid === 1'b1) begin
				word = {word[31:0], rd_data};
				n++;
			end
		end
	endtask : fetch
endmodule : query_host_model

// ===== verif/query_readback_monitor.sv
// Assertion checker for the query readback engine.
`timescale 1ns/1ps
module query_readback_monitor import query_readback_pkg::*; (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic wr_stb,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] fw_version,
	input wire logic spi_path,
	input wire logic rd_stb,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic busy,
	input wire logic bad_instr
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire q20 = clk_en && wr_stb && wr_addr == 8'h20;
	sequence s_temp_reads;
		clk_en && wr_stb && wr_addr == 8'h21 ##1 (clk_en && rd_stb && !wr_stb)[*5];
	endsequence
	property p_cause;
		rd_valid |-> $past(rd_stb);
	endproperty
	a_cause: assert property (p_cause) else $error("answer without read");
	property p_refuse;
		clk_en && rd_stb && !busy && !wr_stb |=> !rd_valid;
	endproperty
	a_refuse: assert property (p_refuse) else $error("answer with nothing pending");
	property p_five;
		s_temp_reads ##1 (clk_en && rd_stb && !wr_stb) |=> !rd_valid;
	endproperty
	a_five: assert property (p_five) else $error("sixth byte answered");
	property p_tail;
		s_temp_reads |=> rd_valid && rd_data == 8'h00;
	endproperty
	a_tail: assert property (p_tail) else $error("tail byte not zero");
	property p_nibble;
		q20 && wr_data[7:4] != 4'h0 |=> bad_instr;
	endproperty
	a_nibble: assert property (p_nibble) else $error("upper nibble accepted");
	property p_phase;
		q20 && wr_data == 8'h0A |=> bad_instr == ($past(fw_version) <= 8'h25);
	endproperty
	a_phase: assert property (p_phase) else $error("phase gate wrong");
	property p_status;
		clk_en && wr_stb && wr_addr == 8'h22 && !spi_path |=> busy;
	endproperty
	a_status: assert property (p_status) else $error("status not loaded");
	property p_unmapped;
		clk_en && wr_stb && !busy && (wr_addr < 8'h20 || wr_addr > 8'h26) |=> !busy;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped write loaded");
endmodule : query_readback_monitor
bind query_register_readback query_readback_monitor i_mon(.*);

// ===== verif/query_register_readback_tb.sv
// Self-checking bench for the query readback engine.
`timescale 1ns/1ps
module query_register_readback_tb import query_readback_pkg::*; ;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	logic spi_path = 1'b0;
	logic wr_stb, rd_stb, rd_valid, busy, bad_instr;
	logic [7:0] wr_addr, wr_data, rd_data, wr_data_hi = 8'h00, fw_version = 8'h30;
	logic [39:0] rf1_freq = 40'hA1A2A3A4A5, sweep_start = 40'hB1B2B3B4B5, sweep_stop = 40'hC1C2C3C4C5;
	logic [39:0] sweep_step = 40'hD1D2D3D4D5, device_info = 40'hE1E2E3E4E5, sweep_entry = 40'h0102030405;
	logic [31:0] dwell_time = 32'h11223344, cycle_count = 32'h55667788, buffer_points = 32'h99AABBCC;
	logic [31:0] phase_float = 32'h42B40000, temp_float = 32'h41C80000;
	logic [15:0] rf1_level = 16'h8401, rf2_freq = 16'h0BB8;
	logic [11:0] sweep_addr = 12'h000, sweep_addr_req;
	logic [13:0] level_dac = 14'h2ABC;
	logic [3:0] list_config = 4'hA, sweep_config = 4'h5;
	logic [14:0] operate_flags = 15'h5A5A;
	logic [6:0] pll_lock = 7'h6B;
	logic [8:0] status_low = 9'h1C3;
	wire [39:0] st = {list_config, sweep_config, 1'b0, operate_flags, pll_lock, status_low};
	logic [39:0] w;
	int n;
	int errors = 0;
	int compares = 0;
	query_register_readback i_dut(.*);
	query_host_model i_host(.*);
	always #12.5 core_clk = ~core_clk;
	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic ask(input logic [7:0] a, input logic [7:0] d, input logic [39:0] exp);
		i_host.query(a, d);
		i_host.fetch(w, n);
		check(w, exp);
		check(40'(n), 40'h5);
	endtask : ask
	task automatic t_rf;
		logic [39:0] tbl [9];
		tbl = '{rf1_freq, sweep_start, sweep_stop, sweep_step, {dwell_time, 8'h00}, {cycle_count, 8'h00},
			{buffer_points, 8'h00}, {rf1_level, 24'h0}, {rf2_freq, 24'h0}};
		for (int c = 0; c <= 8; c++) begin
			ask(8'h20, 8'(c), tbl[c]);
			check(40'(bad_instr), 40'h0);
		end
		$display("rf test done");
	endtask : t_rf
	task automatic t_phase;
		fw_version <= 8'h25;
		i_host.query(8'h20, 8'h0A);
		@(posedge core_clk);
		check(40'(bad_instr), 40'h1);
		fw_version <= 8'h26;
		ask(8'h20, 8'h0A, {phase_float, 8'h00});
		check(40'(bad_instr), 40'h0);
		i_host.query(8'h20, 8'h13);
		@(posedge core_clk);
		check(40'(bad_instr), 40'h1);
		$display("phase test done");
	endtask : t_phase
	task automatic t_status;
		ask(8'h22, 8'h00, st);
		spi_path <= 1'b1;
		i_host.query(8'h22, 8'h00);
		// Let the strobe fall for one edge so the host never writes it twice in one step.
		@(posedge core_clk);
		ask(8'h26, 8'h00, st);
		ask(8'h26, 8'h00, 40'h0000000000);
		spi_path <= 1'b0;
		$display("status test done");
	endtask : t_status
	task automatic t_edge;
		ask(8'h21, 8'h00, {temp_float, 8'h00});
		i_host.fetch(w, n);
		check(40'(n), 40'h0);
		i_host.query(8'h30, 8'h00);
		@(posedge core_clk);
		check(40'(busy), 40'h0);
		i_host.query(8'h21, 8'h00);
		@(posedge core_clk);
		ask(8'h23, 8'h00, device_info);
		$display("edge test done");
	endtask : t_edge
	task automatic t_table;
		wr_data_hi <= 8'h0B;
		i_host.query(8'h24, 8'h5C);
		check(40'(sweep_addr_req), 40'h0000000B5C);
		i_host.fetch(w, n);
		check(w, sweep_entry);
		check(40'(n), 40'h5);
		check(40'(sweep_addr_req), 40'h0000000B5C);
		wr_data_hi <= 8'h00;
		ask(8'h25, 8'h00, {2'b00, level_dac, 24'h000000});
		$display("table test done");
	endtask : t_table
	task automatic conclude;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	initial begin
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_rf();
		t_phase();
		t_status();
		t_edge();
		t_table();
		conclude();
	end
	// About 170 cycles are needed; the limit leaves wide margin.
	initial begin
		#50000;
		errors++;
		conclude();
	end
endmodule : query_register_readback_tb
